// [verilog/bsm_top.sv]
// Strap sampling, clock divide, carrier sense and status pin driver
// Behaviour
// - Protocol clock is modem clock halved
// - Bootloader starts after every reset
// - Straps sampled during start-up after reset
// - Host strap low UART, high I2C
// - Source strap low ROM, high Flash
// - Sector strap ignored when source low
// - Status pins driven only after start-up
// - Transmit pin low while transmitting
// - Activity low when receiving or transmitting
// - Activity routed by host strap level
// - Band-in-use on busy pin when enabled
// - Carrier sense before transmitting
// - Sense source, slot count, length configurable
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module bsm_top
    import bsm_pkg::*;
#(
    parameter int SETTLE_CYC = BSM_STRAP_SETTLE_CYC  // Strap settle cycles
) (
    input  wire logic        pclk,              // Modem core clock
    input  wire logic        presetn,           // Async reset, active low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB enable
    input  wire logic        pwrite,            // APB direction
    input  wire logic [7:0]  paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    input  wire logic        host_sel_in,       // Host select pin input
    input  wire logic        boot_source_activity_pin_in, // Pin input
    output logic             boot_source_activity_pin_out,// Pin output
    output logic             boot_source_activity_pin_oe, // Pin drive
    input  wire logic        boot_sector_transmit_pin_in, // Pin input
    output logic             boot_sector_transmit_pin_out,// Pin output
    output logic             boot_sector_transmit_pin_oe, // Pin drive
    output logic             band_busy_activity_pin_out,  // Pin output
    output logic             band_busy_activity_pin_oe,   // Pin drive
    input  wire bsm_modem_s  modem_in,          // Modem core state
    input  wire logic        tx_request,        // Core wants to transmit
    output logic             tx_grant,          // Channel access granted
    output logic             proto_clk_en,      // Protocol core enable
    output logic             bootloader_run,    // Bootloader running
    output logic             host_is_i2c        // Host select result
);

    // Settle count plus synchroniser delay must fit the 16-bit counter
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65534) begin : g_settle_chk
        $error("SETTLE_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    logic [2:0] pin_meta;   // First stage
    logic [2:0] pin_sync;   // Second stage

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {boot_sector_transmit_pin_in,
                         boot_source_activity_pin_in, host_sel_in};
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Start-up phase: settle, sample straps, bootloader, run
    bsm_phase_e phase;        // Current phase
    logic [15:0] settle_cnt;  // Settle counter, counts up from 0
    bsm_strap_s straps;       // Latched straps
    logic boot_done_wr;       // Software marks bootloader done

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase      <= BSM_SETTLE;
            settle_cnt <= 16'h0000;
            straps     <= '0;
        end else begin
            case (phase)
                BSM_SETTLE: begin
                    // Two extra cycles let the pin levels cross both
                    // synchroniser stages before they are latched
                    if (settle_cnt == 16'(SETTLE_CYC + 1)) begin
                        straps.host_i2c <= pin_sync[0];
                        straps.boot_ext <= pin_sync[1];
                        straps.boot_sect <= pin_sync[1] & pin_sync[2];
                        phase <= BSM_BOOT;
                    end else begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end
                // straps held, only reset reopens sampling
                BSM_BOOT: begin
                    if (boot_done_wr) begin
                        phase <= BSM_RUN;
                    end
                end
                BSM_RUN: begin
                    phase <= BSM_RUN;
                end
                default: begin
                    phase <= BSM_SETTLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bootloader_run <= 1'b0;
            host_is_i2c    <= 1'b0;
        end else begin
            bootloader_run <= (phase == BSM_BOOT);
            host_is_i2c    <= straps.host_i2c;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // protocol clock enable at half rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proto_clk_en <= 1'b0;
        end else begin
            proto_clk_en <= ~proto_clk_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB registers
    logic [31:0] ctrl;   // Control register
    logic [31:0] csma;   // Carrier-sense config
    logic        apb_wr; // Write access phase
    logic        apb_rd; // Read access phase
    logic        hit;    // Mapped address

    always_comb begin
        apb_wr = psel & penable & pwrite & pready;
        apb_rd = psel & penable & ~pwrite & pready;
        hit = (paddr == BSM_STRAP_OFS) || (paddr == BSM_CTRL_OFS) ||
              (paddr == BSM_CSMA_OFS) || (paddr == BSM_STATUS_OFS);
        boot_done_wr = apb_wr && (paddr == BSM_CTRL_OFS) &&
                       pwdata[BSM_CTRL_BOOTDONE_BIT];
    end

    // No wait state: ready goes high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    BSM_STRAP_OFS: begin
                        prdata[BSM_STRAP_HOST_BIT] <= straps.host_i2c;
                        prdata[BSM_STRAP_SRC_BIT]  <= straps.boot_ext;
                        prdata[BSM_STRAP_SECT_BIT] <= straps.boot_sect;
                        prdata[BSM_STRAP_DONE_BIT] <= (phase == BSM_RUN);
                    end
                    BSM_CTRL_OFS:   prdata <= ctrl;
                    BSM_CSMA_OFS:   prdata <= csma;
                    BSM_STATUS_OFS: begin
                        prdata[3:0] <= {modem_in.traffic, modem_in.band_busy,
                                        modem_in.rx_active,
                                        modem_in.tx_active};
                        prdata[4]   <= tx_grant;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Register writes; bootloader-done bit is write-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= BSM_CTRL_RST;
            csma <= BSM_CSMA_RST;
        end else if (apb_wr) begin
            if (paddr == BSM_CTRL_OFS) begin
                ctrl <= {29'h0, pwdata[2:1], 1'b0};
            end
            if (paddr == BSM_CSMA_OFS) begin
                csma <= {pwdata[31:16], pwdata[15:8], 7'h00, pwdata[0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // carrier sense: channel must stay free for all slots
    logic [15:0] tick_cnt;  // Base tick divider
    logic        tick;      // One-cycle tick pulse
    logic [15:0] slot_tm;   // Ticks elapsed in slot
    logic [7:0]  slots_ok;  // Free slots counted
    logic        busy;      // Selected band-in-use source

    always_comb begin
        busy = csma[BSM_CSMA_SRC_BIT] ? modem_in.traffic
                                      : modem_in.band_busy;
    end

    // Tick divider for slot timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else begin
            tick <= (tick_cnt == 16'(BSM_TICK_CYC - 1));
            tick_cnt <= (tick_cnt == 16'(BSM_TICK_CYC - 1)) ? 16'h0000
                                                            : tick_cnt + 16'h0001;
        end
    end

    // Slot counting; a busy band restarts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_tm  <= 16'h0000;
            slots_ok <= 8'h00;
            tx_grant <= 1'b0;
        end else if (!tx_request || phase != BSM_RUN) begin
            slot_tm  <= 16'h0000;
            slots_ok <= 8'h00;
            tx_grant <= 1'b0;
        end else if (busy) begin
            slot_tm  <= 16'h0000;
            slots_ok <= 8'h00;
        end else if (tx_grant) begin
            tx_grant <= 1'b1;
        end else if (slots_ok >= csma[15:8]) begin
            tx_grant <= 1'b1;
        end else if (tick) begin
            if (slot_tm + 16'h0001 >= csma[31:16]) begin
                slot_tm  <= 16'h0000;
                slots_ok <= slots_ok + 8'h01;
            end else begin
                slot_tm <= slot_tm + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status pin drive; released during start-up so straps are read
    logic biu_show;  // Band-in-use shown on busy pin

    always_comb begin
        // band-in-use only when detection and signalling on
        biu_show = ctrl[BSM_CTRL_BIUDET_BIT] & ctrl[BSM_CTRL_BIUSIG_BIT] &
                   busy;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_source_activity_pin_out <= 1'b1;
            boot_source_activity_pin_oe  <= 1'b0;
            boot_sector_transmit_pin_out <= 1'b1;
            boot_sector_transmit_pin_oe  <= 1'b0;
            band_busy_activity_pin_out   <= 1'b1;
            band_busy_activity_pin_oe    <= 1'b0;
        end else if (phase == BSM_RUN) begin
            boot_sector_transmit_pin_out <= ~modem_in.tx_active;
            boot_sector_transmit_pin_oe  <= 1'b1;
            boot_source_activity_pin_oe  <= straps.host_i2c;
            boot_source_activity_pin_out <=
                ~(modem_in.tx_active | modem_in.rx_active);
            band_busy_activity_pin_oe    <=
                ~straps.host_i2c | biu_show;
            band_busy_activity_pin_out   <= straps.host_i2c ? ~biu_show :
                ~(modem_in.tx_active | modem_in.rx_active | biu_show);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    // straps stable
    straps_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase != BSM_SETTLE |=> $stable(straps))
        else $error("straps changed after sampling");
    pins_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase == BSM_SETTLE |=> !boot_sector_transmit_pin_oe)
        else $error("pin driven during start-up");
    sect_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        !straps.boot_ext |-> !straps.boot_sect)
        else $error("boot sector used on ROM boot");
    tx_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase == BSM_RUN ##1 phase == BSM_RUN |->
        boot_sector_transmit_pin_out == !$past(modem_in.tx_active))
        else $error("transmit pin wrong");
    act_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase == BSM_RUN |=> boot_source_activity_pin_oe == straps.host_i2c)
        else $error("activity routing wrong");
    half_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        proto_clk_en |=> !proto_clk_en)
        else $error("protocol enable not halved");
    no_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy && tx_request |=> !tx_grant || $past(tx_grant))
        else $error("grant raised on busy band");
    boot_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase == BSM_BOOT |=> bootloader_run)
        else $error("bootloader not started");
    // busy pin idle in I2C mode unless signalling on
    biu_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase == BSM_RUN && straps.host_i2c && !ctrl[BSM_CTRL_BIUSIG_BIT]
        |=> !band_busy_activity_pin_oe)
        else $error("busy pin driven while signalling off");
    // activity low while receiving or transmitting
    act_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase == BSM_RUN && (modem_in.tx_active || modem_in.rx_active)
        |=> !boot_source_activity_pin_out)
        else $error("activity pin high while modem busy");

    boot_cov_c:  cover property (@(posedge pclk) phase == BSM_RUN);
    grant_cov_c: cover property (@(posedge pclk) tx_grant);
    i2c_cov_c:   cover property (@(posedge pclk) straps.host_i2c);
    biu_cov_c:   cover property (@(posedge pclk) biu_show);

endmodule : bsm_top

// [verilog/bsm_pkg.sv]
// Package: constants, types and register map for the strap and status block
package bsm_pkg;

    // APB register byte offsets
    localparam logic [7:0] BSM_STRAP_OFS     = 8'h00;  // Latched straps, RO
    localparam logic [7:0] BSM_CTRL_OFS      = 8'h04;  // Control, RW
    localparam logic [7:0] BSM_CSMA_OFS      = 8'h08;  // Carrier-sense cfg, RW
    localparam logic [7:0] BSM_STATUS_OFS    = 8'h0C;  // Modem status, RO

    // Strap register fields
    localparam int BSM_STRAP_HOST_BIT    = 0;  // 1 = I2C host, 0 = UART
    localparam int BSM_STRAP_SRC_BIT     = 1;  // 1 = external Flash boot
    localparam int BSM_STRAP_SECT_BIT    = 2;  // Boot sector, 0 if ROM boot
    localparam int BSM_STRAP_DONE_BIT    = 3;  // Start-up finished

    // Control register fields
    localparam int BSM_CTRL_BOOTDONE_BIT = 0;  // Bootloader finished, W1
    localparam int BSM_CTRL_BIUDET_BIT   = 1;  // Band-in-use detection on
    localparam int BSM_CTRL_BIUSIG_BIT   = 2;  // Band-in-use signalling on

    // Carrier-sense config fields
    localparam int BSM_CSMA_SRC_BIT      = 0;   // 1 = valid traffic source
    localparam int BSM_CSMA_SLOTS_LSB    = 8;   // Slot count field
    localparam int BSM_CSMA_SLOTLEN_LSB  = 16;  // Slot length, in ticks

    // Reset values
    localparam logic [31:0] BSM_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] BSM_CSMA_RST = 32'h0004_0400;

    // Timing: settle time of strap pins after reset release
    localparam int BSM_CLK_MHZ        = 250;
    localparam int BSM_STRAP_SETTLE_NS = 100;
    localparam int BSM_STRAP_SETTLE_CYC =
        (BSM_STRAP_SETTLE_NS * BSM_CLK_MHZ + 999) / 1000;
    // Slot tick: 1 us base time unit
    localparam int BSM_TICK_NS  = 1000;
    localparam int BSM_TICK_CYC = BSM_TICK_NS * BSM_CLK_MHZ / 1000;

    // Latched strap set
    typedef struct packed {
        logic host_i2c;   // Host interface select
        logic boot_ext;   // Boot source
        logic boot_sect;  // Boot sector
    } bsm_strap_s;

    // Modem status inputs from the modem core
    typedef struct packed {
        logic tx_active;  // Transmission ongoing
        logic rx_active;  // Active reception
        logic band_busy;  // Raw band-in-use from level detector
        logic traffic;    // Valid protocol traffic seen
    } bsm_modem_s;

    // Start-up phases
    typedef enum logic [1:0] {
        BSM_SETTLE,
        BSM_BOOT,
        BSM_RUN
    } bsm_phase_e;

endpackage : bsm_pkg

// [bench/bsm_board.sv]
// Board model: strap resistors around the shared strap and status pins
`timescale 1ns/10ps
module bsm_board (
    input  wire logic host_strap,  // Host select resistor level
    input  wire logic src_strap,   // Boot source resistor level
    input  wire logic sect_strap,  // Boot sector resistor level
    input  wire logic src_out,     // Device drive, source pin
    input  wire logic src_oe,      // Device enable, source pin
    input  wire logic sect_out,    // Device drive, sector pin
    input  wire logic sect_oe,     // Device enable, sector pin
    output logic      host_wire,   // Level on host select pin
    output logic      src_wire,    // Level on source pin
    output logic      sect_wire    // Level on sector pin
);
    ////////////////////////////////////////////////////////////////////////
    // strap resistor levels
    // Released pins fall back to the resistor, never the last driven value
    assign host_wire = host_strap;
    assign src_wire  = src_oe ? src_out : src_strap;
    assign sect_wire = sect_oe ? sect_out : sect_strap;
endmodule : bsm_board

// [bench/test_boot_strap_and_modem_status.sv]
// Self-checking bench for the strap and modem status block
`timescale 1ns/10ps
module test_boot_strap_and_modem_status;
    import bsm_pkg::*;
    logic        pclk = 0, presetn = 0;          // Clock and reset
    logic        psel = 0, penable = 0;          // APB control
    logic        pwrite = 0;                     // APB direction
    logic [7:0]  paddr = 8'h00;                  // APB address
    logic [31:0] pwdata = 32'h0, prdata, rd;     // APB data
    logic        pready, pslverr, er;            // APB answer
    logic        h_s = 0, s_s = 0, t_s = 1;      // Strap resistor levels
    logic        host_w, src_w, sect_w;          // Pin levels
    logic        src_out, src_oe, sect_out;      // Shared pin drives
    logic        sect_oe, busy_out, busy_oe;     // More pin drives
    bsm_modem_s  modem_in = 4'h0;                // Modem core state
    logic        tx_request = 0, tx_grant;       // Channel access
    logic        proto_clk_en, boot_run, is_i2c; // Misc outputs
    int          fail_count = 0, compares = 0;   // Counters

    // board clock source, modelled here at the core rate
    always #2 pclk = ~pclk;

    // Straps and pull resistors of the board
    bsm_board BRD (.host_strap(h_s), .src_strap(s_s), .sect_strap(t_s),
        .src_out(src_out), .src_oe(src_oe), .sect_out(sect_out),
        .sect_oe(sect_oe), .host_wire(host_w), .src_wire(src_w),
        .sect_wire(sect_w));

    // Short settle count keeps every reset cheap
    bsm_top #(.SETTLE_CYC(2)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_sel_in(host_w),
        .boot_source_activity_pin_in(src_w),
        .boot_source_activity_pin_out(src_out),
        .boot_source_activity_pin_oe(src_oe),
        .boot_sector_transmit_pin_in(sect_w),
        .boot_sector_transmit_pin_out(sect_out),
        .boot_sector_transmit_pin_oe(sect_oe),
        .band_busy_activity_pin_out(busy_out),
        .band_busy_activity_pin_oe(busy_oe), .modem_in(modem_in),
        .tx_request(tx_request), .tx_grant(tx_grant),
        .proto_clk_en(proto_clk_en), .bootloader_run(boot_run),
        .host_is_i2c(is_i2c));

    ////////////////////////////////////////////////////////////////////////
    // Compare helpers
    task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    // One APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait states are the slave's; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reset with given strap levels; pins must stay released meanwhile
    task do_reset(input logic h, input logic s, input logic t);
        presetn    <= 0;
        h_s        <= h;
        s_s        <= s;
        t_s        <= t;
        modem_in   <= 4'h0;
        tx_request <= 0;
        repeat (10) @(posedge pclk);
        chk_bit("oe in reset", 1'b0, src_oe | sect_oe | busy_oe);
        presetn <= 1;
        repeat (10) @(posedge pclk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // Every strap combination, then straps moved after sampling
    task t_straps;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[0], i[1], i[2]);
            apb(0, BSM_STRAP_OFS, 32'h0);
            chk_word("straps", {29'h0, i[1] & i[2], i[1], i[0]}, rd & 7);
            chk_bit("host i2c", i[0], is_i2c);
            chk_bit("boot run", 1'b1, boot_run);
            chk_bit("oe boot", 1'b0, src_oe | sect_oe | busy_oe);
        end
        h_s <= 0; s_s <= 0; t_s <= 0;
        apb(0, BSM_STRAP_OFS, 32'h0);
        chk_word("held", 32'h7, rd & 7);
    endtask : t_straps

    // Run phase: status pins per modem state and host mode
    task t_run(input logic h);
        do_reset(h, 0, 1);
        apb(0, BSM_CTRL_OFS, 32'h0);
        chk_word("ctrl rst", BSM_CTRL_RST, rd);
        apb(0, BSM_CSMA_OFS, 32'h0);
        chk_word("csma rst", BSM_CSMA_RST, rd);
        apb(0, 8'h10, 32'h0);
        chk_bit("unmapped", 1'b1, er);
        apb(1, BSM_CTRL_OFS, 32'h1);
        repeat (4) @(posedge pclk);
        chk_bit("boot run", 1'b0, boot_run);
        chk_bit("oe run", 1'b1, sect_oe & (h ? src_oe : busy_oe));
        for (int j = 0; j < 4; j++) begin
            modem_in <= bsm_modem_s'({j[0], j[1], 2'b00});
            repeat (3) @(posedge pclk);
            chk_bit("tx pin", ~j[0], sect_w);
            chk_bit("act pin", ~(j[0] | j[1]), h ? src_w : busy_out);
        end
        // Band-in-use on the busy pin, in both host modes
        modem_in <= 4'b0010;
        apb(1, BSM_CTRL_OFS, 32'h7);
        repeat (3) @(posedge pclk);
        chk_bit("biu on", 1'b0, busy_out);
        chk_bit("biu oe on", 1'b1, busy_oe);
        apb(1, BSM_CTRL_OFS, 32'h3);
        repeat (3) @(posedge pclk);
        chk_bit("biu off", 1'b1, busy_out);
        chk_bit("biu oe off", ~h, busy_oe);
    endtask : t_run

    // Protocol clock enable alternates every cycle
    task t_clk;
        logic p;
        // Every look is taken at an edge, before that edge's update
        @(posedge pclk);
        p = proto_clk_en;
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            chk_bit("half rate", ~p, proto_clk_en);
            p = proto_clk_en;
        end
    endtask : t_clk

    // One slot of two 1 us ticks: the tick phase is free running, so a
    // free band is granted after 252 to 501 cycles, never before
    task t_csma(input logic src);
        int n;
        n = 0;
        apb(1, BSM_CSMA_OFS, {16'd2, 8'd1, 7'd0, src});
        modem_in <= 4'b0010;
        tx_request <= 1;
        repeat (240) @(posedge pclk);
        chk_bit("no early", 1'b0, tx_grant);
        while (tx_grant !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk_bit("grant", src, tx_grant);
        tx_request <= 0;
        modem_in <= 4'h0;
        repeat (5) @(posedge pclk);
    endtask : t_csma

    ////////////////////////////////////////////////////////////////////////
    // Verdict
    task wrap_up;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        t_straps();
        t_run(1);
        t_run(0);
        t_clk();
        t_csma(1);
        t_csma(0);
        wrap_up();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule : test_boot_strap_and_modem_status
